// File: verilog/irq_route_pkg.sv
// constants and carrier types for the motion interrupt routing block
// assumes one 125 mhz clock and a byte-wide register port inside the sensor
package irq_route_pkg;
    // register offsets
    localparam logic [7:0] OFS_MOTION_FLAG = 8'h09;
    localparam logic [7:0] OFS_NEWDATA_FLAG = 8'h0a;
    localparam logic [7:0] OFS_ENABLE_A = 8'h16;
    localparam logic [7:0] OFS_ENABLE_B = 8'h17;
    localparam logic [7:0] OFS_PIN1_ROUTE = 8'h19;
    localparam logic [7:0] OFS_DATA_ROUTE = 8'h1a;
    localparam logic [7:0] OFS_PIN2_ROUTE = 8'h1b;
    localparam logic [7:0] OFS_OUT_CFG = 8'h20;
    localparam logic [7:0] OFS_LATCH = 8'h21;
    localparam logic [7:0] OFS_FALL_DELAY = 8'h22;
    localparam logic [7:0] OFS_FALL_THR = 8'h23;
    localparam logic [7:0] OFS_FALL_MODE = 8'h24;
    // values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_FALL_DELAY = 8'h09;
    localparam logic [7:0] RST_FALL_THR = 8'h30;
    localparam logic [7:0] RST_FALL_MODE = 8'h01;
    // field positions
    localparam int SRC_LO = 6;
    localparam int EN_STAP = 5;
    localparam int EN_DTAP = 4;
    localparam int EN_ORIENT = 3;
    localparam int MUTE_BIT = 7;
    localparam int MUTE_LO = 5;
    localparam int EN_NEWDATA = 4;
    localparam int EN_FALL = 3;
    localparam int CLEAR_BIT = 7;
    localparam int FALL_MODE_BIT = 2;
    // timing
    localparam int CLK_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int FALL_STEP_MS = 2;
    localparam int TIMER_W = 13;
    // hold time per latch code in ms, zero where the code is not timed
    localparam logic [12:0] HOLD_MS [16] = '{13'h0000, 13'h00fa, 13'h01f4, 13'h03e8,
        13'h07d0, 13'h0fa0, 13'h1f40, 13'h0000, 13'h0000, 13'h0001, 13'h0001,
        13'h0002, 13'h0019, 13'h0032, 13'h0064, 13'h0000};
    // mute time per code in ms: 100 ms, 1 s, 2 s, 4 s
    localparam logic [12:0] MUTE_MS [4] = '{13'h0064, 13'h03e8, 13'h07d0, 13'h0fa0};

    // motion sources in routing bit order
    typedef struct packed {
        logic significant_motion;
        logic orient;
        logic single_tap;
        logic double_tap;
        logic tilt;
        logic [2:0] activity;
        logic step;
    } motion_src_t;

    // fifo and sample events
    typedef struct packed {
        logic new_data;
        logic watermark;
        logic fifo_full;
    } data_src_t;

    // axis magnitudes in freefall threshold units
    typedef struct packed {
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] z;
    } accel_mag_t;
endpackage

// File: verilog/motion_sensor_irq_routing.sv
// interrupt enable, mute, routing, pin shaping and freefall timing
// assumes detection engines on the same clock give one-cycle event pulses
`timescale 1ns/100ps
module motion_sensor_irq_routing #(
    parameter int MS_CYCLES = irq_route_pkg::MS_CYCLES
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] reg_rdata_o,
    input wire irq_route_pkg::motion_src_t motion_i,
    input wire irq_route_pkg::data_src_t data_i,
    input wire irq_route_pkg::accel_mag_t accel_i,
    output logic [1:0] data_source_o,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe_o,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe_o
);
    logic [7:0] irq_enable_a, irq_enable_b, pin1_motion_routing, data_event_routing;
    logic [7:0] pin2_motion_routing, pin_output_config, pin_latch_mode;
    logic [7:0] fall_delay, fall_threshold, fall_mode, motion_flag;
    logic newdata_flag;
    logic [7:0] next_enable_a, next_enable_b, next_route1, next_route_d, next_route2;
    logic [7:0] next_out_cfg, next_latch, next_fall_delay, next_fall_thr, next_fall_mode;
    logic [7:0] next_motion_flag, next_rdata;
    logic next_newdata_flag;
    logic [1:0] next_data_source;
    logic [31:0] ms_cnt, next_ms_cnt;
    logic ms_tick, next_ms_tick;
    logic [12:0] mute_cnt, next_mute_cnt;
    logic [9:0] fall_cnt, next_fall_cnt;
    logic [9:0] fall_need;
    logic [9:0] mag_sum;
    logic fall_cond, fall_evt, clear_cmd, muted;
    logic [7:0] motion_gated;
    logic [2:0] data_gated;
    logic [1:0] pin_act, pin_hold, next_pin_hold, pin_out, next_pin_out, pin_oe, next_pin_oe;
    logic [12:0] pin_timer [2];
    logic [12:0] next_pin_timer [2];

    wire wr_en = reg_wr_i;
    assign clear_cmd = wr_en && reg_addr_i == irq_route_pkg::OFS_OUT_CFG &&
        reg_wdata_i[irq_route_pkg::CLEAR_BIT];
    assign muted = mute_cnt != 13'h0000;

    // register writes; the clear bit is a command and never stored
    always_comb begin
        next_enable_a = irq_enable_a;
        next_enable_b = irq_enable_b;
        next_route1 = pin1_motion_routing;
        next_route_d = data_event_routing;
        next_route2 = pin2_motion_routing;
        next_out_cfg = pin_output_config;
        next_latch = pin_latch_mode;
        next_fall_delay = fall_delay;
        next_fall_thr = fall_threshold;
        next_fall_mode = fall_mode;
        if (wr_en) begin
            case (reg_addr_i)
                irq_route_pkg::OFS_ENABLE_A: next_enable_a = reg_wdata_i;
                irq_route_pkg::OFS_ENABLE_B: next_enable_b = {reg_wdata_i[7:3], 3'h0};
                irq_route_pkg::OFS_PIN1_ROUTE: next_route1 = reg_wdata_i;
                irq_route_pkg::OFS_DATA_ROUTE: next_route_d = {reg_wdata_i[7:5], 2'h0, reg_wdata_i[2:0]};
                irq_route_pkg::OFS_PIN2_ROUTE: next_route2 = reg_wdata_i;
                irq_route_pkg::OFS_OUT_CFG: next_out_cfg = {4'h0, reg_wdata_i[3:0]};
                irq_route_pkg::OFS_LATCH: next_latch = reg_wdata_i;
                irq_route_pkg::OFS_FALL_DELAY: next_fall_delay = reg_wdata_i;
                irq_route_pkg::OFS_FALL_THR: next_fall_thr = reg_wdata_i;
                irq_route_pkg::OFS_FALL_MODE: next_fall_mode = {5'h00, reg_wdata_i[2:0]};
                default: ;
            endcase
        end
        // mute bit reads back as mute running
        if (!muted && !(wr_en && reg_addr_i == irq_route_pkg::OFS_ENABLE_B)) begin
            next_enable_b[irq_route_pkg::MUTE_BIT] = 1'b0;
        end
        next_data_source = next_enable_a[7:irq_route_pkg::SRC_LO];
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            irq_enable_a <= irq_route_pkg::RST_ZERO;
            irq_enable_b <= irq_route_pkg::RST_ZERO;
            pin1_motion_routing <= irq_route_pkg::RST_ZERO;
            data_event_routing <= irq_route_pkg::RST_ZERO;
            pin2_motion_routing <= irq_route_pkg::RST_ZERO;
            pin_output_config <= irq_route_pkg::RST_ZERO;
            pin_latch_mode <= irq_route_pkg::RST_ZERO;
            fall_delay <= irq_route_pkg::RST_FALL_DELAY;
            fall_threshold <= irq_route_pkg::RST_FALL_THR;
            fall_mode <= irq_route_pkg::RST_FALL_MODE;
            data_source_o <= 2'h0;
        end else begin
            irq_enable_a <= next_enable_a;
            irq_enable_b <= next_enable_b;
            pin1_motion_routing <= next_route1;
            data_event_routing <= next_route_d;
            pin2_motion_routing <= next_route2;
            pin_output_config <= next_out_cfg;
            pin_latch_mode <= next_latch;
            fall_delay <= next_fall_delay;
            fall_threshold <= next_fall_thr;
            fall_mode <= next_fall_mode;
            data_source_o <= next_data_source;
        end
    end

    // millisecond tick and mute timer
    always_comb begin
        next_ms_tick = 1'b0;
        next_ms_cnt = ms_cnt + 32'h1;
        if (ms_cnt >= 32'(MS_CYCLES - 1)) begin
            next_ms_cnt = 32'h0;
            next_ms_tick = 1'b1;
        end
        next_mute_cnt = mute_cnt;
        if (ms_tick && muted) begin
            next_mute_cnt = mute_cnt - 13'h0001;
        end
        if (wr_en && reg_addr_i == irq_route_pkg::OFS_ENABLE_B && reg_wdata_i[irq_route_pkg::MUTE_BIT]) begin
            next_mute_cnt = irq_route_pkg::MUTE_MS[reg_wdata_i[6:irq_route_pkg::MUTE_LO]];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ms_cnt <= 32'h0;
            ms_tick <= 1'b0;
            mute_cnt <= 13'h0000;
        end else begin
            ms_cnt <= next_ms_cnt;
            ms_tick <= next_ms_tick;
            mute_cnt <= next_mute_cnt;
        end
    end

    // freefall: low magnitude held for the programmed time
    assign mag_sum = 10'(accel_i.x) + 10'(accel_i.y) + 10'(accel_i.z);
    assign fall_need = (10'(fall_delay) + 10'h001) * 10'(irq_route_pkg::FALL_STEP_MS);
    always_comb begin
        if (fall_mode[irq_route_pkg::FALL_MODE_BIT]) begin
            fall_cond = mag_sum < 10'(fall_threshold);
        end else begin
            fall_cond = accel_i.x < fall_threshold && accel_i.y < fall_threshold &&
                accel_i.z < fall_threshold;
        end
        next_fall_cnt = fall_cnt;
        if (!fall_cond) begin
            next_fall_cnt = 10'h000;
        end else if (ms_tick && fall_cnt != 10'h3ff) begin
            next_fall_cnt = fall_cnt + 10'h001;
        end
    end
    assign fall_evt = fall_cond && ms_tick && fall_cnt + 10'h001 == fall_need;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fall_cnt <= 10'h000;
        end else begin
            fall_cnt <= next_fall_cnt;
        end
    end

    // mute gating of every source, enable gating of orient, taps, activity, freefall and new data
    always_comb begin
        motion_gated = '0;
        motion_gated[7] = motion_i.significant_motion;
        motion_gated[6] = motion_i.orient && irq_enable_a[irq_route_pkg::EN_ORIENT];
        motion_gated[5] = motion_i.single_tap && irq_enable_a[irq_route_pkg::EN_STAP];
        motion_gated[4] = motion_i.double_tap && irq_enable_a[irq_route_pkg::EN_DTAP];
        motion_gated[3] = motion_i.tilt;
        motion_gated[2] = |(motion_i.activity & irq_enable_a[2:0]);
        motion_gated[1] = motion_i.step;
        motion_gated[0] = fall_evt && irq_enable_b[irq_route_pkg::EN_FALL];
        data_gated = {data_i.new_data && irq_enable_b[irq_route_pkg::EN_NEWDATA],
            data_i.watermark, data_i.fifo_full};
        if (muted) begin
            motion_gated = '0;
            data_gated = '0;
        end
    end

    // source flags: set wins over the clear command
    always_comb begin
        next_motion_flag = clear_cmd ? 8'h00 : motion_flag;
        next_newdata_flag = clear_cmd ? 1'b0 : newdata_flag;
        next_motion_flag = next_motion_flag | {motion_gated[1], motion_gated[6], motion_gated[5],
            motion_gated[4], motion_gated[7], motion_gated[2], motion_gated[3], motion_gated[0]};
        next_newdata_flag = next_newdata_flag | data_gated[2];
    end

    // routing to the two pins
    assign pin_act[0] = |(motion_gated & pin1_motion_routing) |
        |(data_event_routing[2:0] & {data_gated[0], data_gated[1], data_gated[2]});
    assign pin_act[1] = |(motion_gated & pin2_motion_routing) |
        |(data_event_routing[7:5] & data_gated);

    // per pin latch, hold timer, polarity and driver
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic [3:0] mode;
            logic timed, latched, asserted, level;
            assign mode = pin_latch_mode[gi*4 +: 4];
            assign latched = mode[2:0] == 3'h7;
            assign timed = mode[2:0] != 3'h0 && !latched;
            always_comb begin
                next_pin_hold[gi] = pin_hold[gi] && latched && !clear_cmd;
                if (pin_act[gi] && latched) begin
                    next_pin_hold[gi] = 1'b1;
                end
                next_pin_timer[gi] = pin_timer[gi];
                if (clear_cmd || !timed) begin
                    next_pin_timer[gi] = 13'h0000;
                end else if (ms_tick && pin_timer[gi] != 13'h0000) begin
                    next_pin_timer[gi] = pin_timer[gi] - 13'h0001;
                end
                if (pin_act[gi] && timed) begin
                    next_pin_timer[gi] = irq_route_pkg::HOLD_MS[mode];
                end
                asserted = pin_act[gi] || pin_hold[gi] || pin_timer[gi] != 13'h0000;
                level = asserted ^ pin_output_config[gi*2];
                next_pin_out[gi] = pin_output_config[gi*2+1] ? 1'b0 : level;
                next_pin_oe[gi] = pin_output_config[gi*2+1] ? !level : 1'b1;
            end
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    pin_hold[gi] <= 1'b0;
                    pin_timer[gi] <= 13'h0000;
                    pin_out[gi] <= 1'b0;
                    pin_oe[gi] <= 1'b1;
                end else begin
                    pin_hold[gi] <= next_pin_hold[gi];
                    pin_timer[gi] <= next_pin_timer[gi];
                    pin_out[gi] <= next_pin_out[gi];
                    pin_oe[gi] <= next_pin_oe[gi];
                end
            end
        end
    endgenerate
    assign irq_pin_a_o = pin_out[0];
    assign irq_pin_a_oe_o = pin_oe[0];
    assign irq_pin_b_o = pin_out[1];
    assign irq_pin_b_oe_o = pin_oe[1];

    // read data, one cycle after the address
    always_comb begin
        case (reg_addr_i)
            irq_route_pkg::OFS_MOTION_FLAG: next_rdata = motion_flag;
            irq_route_pkg::OFS_NEWDATA_FLAG: next_rdata = {7'h00, newdata_flag};
            irq_route_pkg::OFS_ENABLE_A: next_rdata = irq_enable_a;
            irq_route_pkg::OFS_ENABLE_B: next_rdata = irq_enable_b;
            irq_route_pkg::OFS_PIN1_ROUTE: next_rdata = pin1_motion_routing;
            irq_route_pkg::OFS_DATA_ROUTE: next_rdata = data_event_routing;
            irq_route_pkg::OFS_PIN2_ROUTE: next_rdata = pin2_motion_routing;
            irq_route_pkg::OFS_OUT_CFG: next_rdata = pin_output_config;
            irq_route_pkg::OFS_LATCH: next_rdata = pin_latch_mode;
            irq_route_pkg::OFS_FALL_DELAY: next_rdata = fall_delay;
            irq_route_pkg::OFS_FALL_THR: next_rdata = fall_threshold;
            irq_route_pkg::OFS_FALL_MODE: next_rdata = fall_mode;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            motion_flag <= 8'h00;
            newdata_flag <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            motion_flag <= next_motion_flag;
            newdata_flag <= next_newdata_flag;
            reg_rdata_o <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    sequence src_write;
        wr_en && reg_addr_i == irq_route_pkg::OFS_ENABLE_A;
    endsequence
    sequence clear_alone;
        clear_cmd && pin_act == 2'b00;
    endsequence
    AST_SRC_FIELD: assert property (src_write |=> data_source_o == $past(reg_wdata_i[7:6]))
        else $error("source field not applied");
    AST_TAP_GATE: assert property ($rose(motion_flag[5]) |-> $past(irq_enable_a[irq_route_pkg::EN_STAP]))
        else $error("tap event passed while disabled");
    AST_ACT_AXIS: assert property ($rose(motion_flag[2]) |-> $past(|(motion_i.activity & irq_enable_a[2:0])))
        else $error("activity passed on disabled axis");
    AST_NEWDATA_FLAG: assert property ($rose(newdata_flag) |-> $past(irq_enable_b[4] && data_i.new_data))
        else $error("new data flag without enable");
    AST_MUTE: assert property (muted |-> motion_gated == 8'h00 && data_gated == 3'h0)
        else $error("event passed while muted");
    AST_CLEAR: assert property (clear_alone |=> pin_hold == 2'b00 && pin_timer[0] == 13'h0000)
        else $error("latched pin not cleared");
    AST_PUSH_PULL: assert property (pin_act[0] && pin_output_config[1:0] == 2'b00 |=>
        irq_pin_a_o && irq_pin_a_oe_o)
        else $error("push-pull pin not driven high");
    AST_LOW_ACTIVE: assert property (pin_act[1] && pin_output_config[3:2] == 2'b01 |=>
        !irq_pin_b_o && irq_pin_b_oe_o)
        else $error("active low pin not driven low");
    AST_LATCH_HOLD: assert property (pin_hold[0] && !clear_cmd |=> pin_hold[0] || !g_pin[0].latched)
        else $error("latched pin dropped without clear");
    AST_FALL_TIME: assert property (fall_evt |->
        int'(fall_cnt) == (int'(fall_delay) + 1) * irq_route_pkg::FALL_STEP_MS - 1)
        else $error("freefall signalled at wrong time");
endmodule

// File: tb/irq_host_model.sv
// host side of the interrupt pins: resolves each wire as the processor sees it
// assumes a pull-up on each wire, which the open-drain setting needs
`timescale 1ns/100ps
module irq_host_model (
    input wire logic pin_a_i,
    input wire logic pin_a_oe_i,
    input wire logic pin_b_i,
    input wire logic pin_b_oe_i,
    output logic wire_a_o,
    output logic wire_b_o
);
    // a released wire floats to the pull-up level, never to the last value
    assign wire_a_o = pin_a_oe_i ? pin_a_i : 1'b1;
    assign wire_b_o = pin_b_oe_i ? pin_b_i : 1'b1;
endmodule

// File: tb/motion_sensor_irq_routing_test.sv
// self-checking bench for the motion interrupt routing block
// assumes MS_CYCLES shortened to 10, so every ms figure is ten clocks
`timescale 1ns/100ps
module motion_sensor_irq_routing_test;
    localparam int MS = 10;
    localparam int MW = $bits(irq_route_pkg::motion_src_t);
    localparam logic [7:0] OFFS [11] = '{8'h16, 8'h17, 8'h19, 8'h1a, 8'h1b, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
    localparam logic [7:0] RSTV [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h09, 8'h30, 8'h01, 8'h00};
    localparam logic [7:0] MASK [11] = '{8'hff, 8'h18, 8'hff, 8'he7, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00};
    localparam logic [3:0] HC [7] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h1};
    localparam int HMS [7] = '{1, 1, 2, 25, 50, 100, 250};
    localparam int MMS [4] = '{100, 1000, 2000, 4000};
    localparam logic [23:0] FFA [4] = '{24'h2f2f30, 24'h2f2f2f, 24'h101010, 24'h0f1010};
    localparam logic FFE [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_rdata_o;
    irq_route_pkg::motion_src_t motion_i = '0;
    irq_route_pkg::data_src_t data_i = '0;
    irq_route_pkg::accel_mag_t accel_i = '1;
    logic [1:0] data_source_o;
    logic irq_pin_a_o;
    logic irq_pin_a_oe_o;
    logic irq_pin_b_o;
    logic irq_pin_b_oe_o;
    logic wire_a;
    logic wire_b;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] lfsr = 32'h69bd;
    logic [7:0] rv;
    logic [7:0] wv;
    logic [7:0] cfg [6];
    int n;

    // free-running 125 mhz clock
    always #4 clock_i = ~clock_i;

    motion_sensor_irq_routing #(.MS_CYCLES(MS)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
        .motion_i(motion_i), .data_i(data_i), .accel_i(accel_i), .data_source_o(data_source_o),
        .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe_o(irq_pin_a_oe_o),
        .irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe_o(irq_pin_b_oe_o));

    irq_host_model host (.pin_a_i(irq_pin_a_o), .pin_a_oe_i(irq_pin_a_oe_o), .pin_b_i(irq_pin_b_o),
        .pin_b_oe_i(irq_pin_b_oe_o), .wire_a_o(wire_a), .wire_b_o(wire_b));

    // random source: shift register with feedback taps
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected active state of both pins from enables, routing and events
    function automatic logic [1:0] exp_pins(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] m1,
        input logic [7:0] md, input logic [7:0] m3, input irq_route_pkg::motion_src_t m,
        input irq_route_pkg::data_src_t d);
        logic [7:0] src;
        logic [2:0] dv;
        src = {m.significant_motion, m.orient & ea[3], m.single_tap & ea[5], m.double_tap & ea[4], m.tilt,
            |(m.activity & ea[2:0]), m.step, 1'b0};
        dv = {d.new_data & eb[4], d.watermark, d.fifo_full};
        return {(|(src & m3)) | (|(dv & md[7:5])), (|(src & m1)) | (|({dv[0], dv[1], dv[2]} & md[2:0]))};
    endfunction

    function automatic logic in_rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    // inputs always move one ns after the rising edge
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_i = a;
        step(1);
        d = reg_rdata_o;
    endtask

    // pin level, enable and wire level for both pins
    task automatic chk_pins(input logic [1:0] act, input logic [3:0] oc);
        logic la;
        logic lb;
        la = act[0] ^ oc[0];
        lb = act[1] ^ oc[2];
        chk("pin_a", {5'h0, oc[1] ? 1'b0 : la, oc[1] ? ~la : 1'b1, la}, {5'h0, irq_pin_a_o, irq_pin_a_oe_o, wire_a});
        chk("pin_b", {5'h0, oc[3] ? 1'b0 : lb, oc[3] ? ~lb : 1'b1, lb}, {5'h0, irq_pin_b_o, irq_pin_b_oe_o, wire_b});
    endtask

    task automatic tap;
        motion_i.single_tap = 1'b1;
        step(1);
        motion_i.single_tap = 1'b0;
    endtask

    // cycles a condition lasts: 0 pin a high, 1 mute bit set, 2 pin a still low
    task automatic run_len(input int sel, input int lim, output int len);
        len = 0;
        while (len < lim && (sel == 0 ? irq_pin_a_o === 1'b1 : sel == 1 ? reg_rdata_o[7] === 1'b1 :
            irq_pin_a_o !== 1'b1)) begin
            step(1);
            len++;
        end
        if (len == lim && sel != 2) begin
            miscompares++;
            end_of_test();
        end
    endtask

    // hang guard
    initial begin
        #(8 * 99000);
        miscompares++;
        end_of_test();
    end

    // main sequence
    initial begin
        step(20);
        sys_rst_i = 1'b0;
        // reset values, then write and read back with stored-bit masks
        for (int k = 0; k < 11; k++) begin
            rd(OFFS[k], rv);
            chk("reset_value", RSTV[k], rv);
            lfsr = next_rand(lfsr);
            wv = (k == 1) ? lfsr[7:0] & 8'h18 : lfsr[7:0];
            wr(OFFS[k], wv);
            rd(OFFS[k], rv);
            chk("readback", wv & MASK[k], rv);
            if (k == 0) chk("data_source", {6'h0, wv[7:6]}, {6'h0, data_source_o});
        end
        // random enables, routing and pin shapes, non-latched
        wr(8'h21, 8'h00);
        for (int i = 0; i < 240; i++) begin
            if (i % 24 == 0) begin
                motion_i = '0;
                data_i = '0;
                for (int k = 0; k < 6; k++) begin
                    lfsr = next_rand(lfsr);
                    cfg[k] = lfsr[7:0];
                    wr(OFFS[k], (k == 1) ? lfsr[7:0] & 8'h10 : (k == 5) ? lfsr[7:0] & 8'h0f : lfsr[7:0]);
                end
                cfg[1] = cfg[1] & 8'h10;
            end
            lfsr = next_rand(lfsr);
            motion_i = (i % 24 == 1) ? '1 : lfsr[MW-1:0];
            data_i = lfsr[MW+2:MW];
            step(1);
            chk_pins(exp_pins(cfg[0], cfg[1], cfg[2], cfg[3], cfg[4], motion_i, data_i), cfg[5][3:0]);
        end
        motion_i = '0;
        data_i = '0;
        // single tap routed to both pins, pin a latched and pin b latched by the other code
        wr(8'h16, 8'h20);
        wr(8'h17, 8'h00);
        wr(8'h19, 8'h20);
        wr(8'h1a, 8'h00);
        wr(8'h1b, 8'h20);
        wr(8'h20, 8'h80); // drops flags left by the random phase
        wr(8'h21, 8'hf7);
        tap();
        step(4);
        chk_pins(2'b11, 4'h0);
        rd(8'h09, rv);
        chk("tap_flag", 8'h20, rv);
        wr(8'h20, 8'h80);
        chk_pins(2'b00, 4'h0);
        rd(8'h09, rv);
        chk("flags_cleared", 8'h00, rv);
        // timed holds on pin a
        for (int k = 0; k < 7; k++) begin
            wr(8'h21, {4'h0, HC[k]});
            tap();
            run_len(0, HMS[k] * MS + 20, n);
            chk("hold_len", 8'h01, {7'h0, in_rng(n, (HMS[k] - 1) * MS, HMS[k] * MS + 2)});
        end
        // every mute time, with an event swallowed while it runs
        wr(8'h21, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h17, {1'b1, k[1:0], 5'h00});
            tap();
            chk_pins(2'b00, 4'h0);
            reg_addr_i = 8'h17;
            run_len(1, MMS[k] * MS + 20, n);
            chk("mute_len", 8'h01, {7'h0, in_rng(n, (MMS[k] - 1) * MS, MMS[k] * MS + 4)});
        end
        tap();
        chk_pins(2'b11, 4'h0);
        // freefall: threshold boundary, single then sum mode, 6 ms delay
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h08);
        wr(8'h19, 8'h01);
        wr(8'h1b, 8'h00);
        wr(8'h22, 8'h02);
        wr(8'h23, 8'h30);
        wr(8'h24, 8'h00);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(8'h24, 8'h04);
            accel_i = FFA[k];
            run_len(2, 80, n);
            chk("fall_fire", {7'h0, FFE[k]}, {7'h0, in_rng(n, 5 * MS - 1, 6 * MS + 3)});
            accel_i = '1;
            step(3);
        end
        end_of_test();
    end
endmodule
